/* dv/charge_ctrl_monitor.sv */
// Assertion checker for the charge mode controller ports.
module charge_ctrl_monitor (
   // Clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rstn_i,
   // Flags and charger outputs
   input  wire logic [chg_pkg::NFLAGS-1:0] flags_i,
   input  wire logic                       chg_en_o,
   input  wire chg_pkg::reg_sel_t          reg_sel_o,
   input  wire chg_pkg::level_t            level_o,
   input  wire logic                       charge_status_n_o,
   input  wire logic                       charge_status_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   // --------------------------------------------------------------
   // Checks; flags reach the outputs three edges after they change, the high-mode flag four.
   // --------------------------------------------------------------
   a_pin_level: assert property (charge_status_n_o == !charge_status_oe_o)
      else $error("status pin and its enable disagree");
   a_high_off: assert property (flags_i[3] [*4] |=> !chg_en_o && !charge_status_oe_o)
      else $error("high mode did not stop charging");
   a_supply_off: assert property (!flags_i[0] [*4] |=> !chg_en_o && !charge_status_oe_o)
      else $error("charging without supply");
   a_en_sel: assert property (chg_en_o == (reg_sel_o != chg_pkg::REG_OFF))
      else $error("enable and selector disagree");
   a_pre_cc: assert property ((reg_sel_o == chg_pkg::REG_CC && $past(reg_sel_o) == chg_pkg::REG_PRE)
      |-> $past(flags_i[4], 3))
      else $error("fast charge without threshold");
   a_cc_cv: assert property ((reg_sel_o == chg_pkg::REG_CV && $past(reg_sel_o) == chg_pkg::REG_CC)
      |-> $past(flags_i[5], 3))
      else $error("voltage mode without transition level");
   a_cv_cc: assert property ((reg_sel_o == chg_pkg::REG_CC && $past(reg_sel_o) == chg_pkg::REG_CV)
      |-> $past(flags_i[8], 3))
      else $error("revert without overcurrent");
   a_pre_level: assert property ((reg_sel_o == chg_pkg::REG_PRE && $past(reg_sel_o) == chg_pkg::REG_PRE)
      |-> level_o == chg_pkg::LVL_20)
      else $error("pre-charge level not lowest");
   a_level_up: assert property ((reg_sel_o == chg_pkg::REG_CC && $past(reg_sel_o) == chg_pkg::REG_CC
      && $past(reg_sel_o, 2) == chg_pkg::REG_CC) |-> level_o >= $past(level_o))
      else $error("soft-start level went down");
endmodule

bind charge_ctrl charge_ctrl_monitor u_mon (.clk_i(clk_i), .rstn_i(rstn_i), .flags_i(flags_i),
   .chg_en_o(chg_en_o), .reg_sel_o(reg_sel_o), .level_o(level_o),
   .charge_status_n_o(charge_status_n_o), .charge_status_oe_o(charge_status_oe_o));

/* dv/host_gpio_model.sv */
// Host GPIO model that drives the three-level mode input as comparator flags.
module host_gpio_model #(
   parameter int unsigned PULL_CYC = 2
) (
   // Clock
   input  wire logic clk_i,
   // GPIO control: drive_i low means the pin is an input
   input  wire logic drive_i,
   input  wire logic val_i,
   // Comparator flags seen at the pin
   output logic      mode_low_o,
   output logic      mode_high_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] pull_q = 4'h0;

   // A pin released after high stays high, so pull it down briefly first.
   always_ff @(posedge clk_i) begin
      if (drive_i) begin
         pull_q <= val_i ? PULL_CYC[3:0] : 4'h0;
      end else if (pull_q != 4'h0) begin
         pull_q <= pull_q - 4'h1;
      end
   end

   // Driving 0 is low range, 1 is high range, released is mid range.
   assign mode_low_o  = drive_i ? !val_i : (pull_q != 4'h0);
   assign mode_high_o = drive_i && val_i;
endmodule

/* dv/tb.sv */
// Self-checking testbench of the charge mode controller.
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_i, rstn_i, cyc, stb, we, ack, drv, dval, m_low, m_high, chg_en, st_n, st_oe;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, q;
   logic [8:0]  fl;
   chg_pkg::reg_sel_t reg_sel;
   chg_pkg::level_t   level;
   int fail_count, checked;

   // Short counts keep the run brief; all waits follow from them.
   charge_ctrl #(.STATUS_MIN_CYC(20), .SOFT_STEP_CYC(4)) DUT (.clk_i(clk_i), .rstn_i(rstn_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .flags_i({fl[8:4], m_high, m_low, fl[1:0]}),
      .chg_en_o(chg_en), .reg_sel_o(reg_sel), .level_o(level), .charge_status_n_o(st_n),
      .charge_status_oe_o(st_oe));
   host_gpio_model HOST (.clk_i(clk_i), .drive_i(drv), .val_i(dval), .mode_low_o(m_low),
      .mode_high_o(m_high));

   // Clock at 200 MHz.
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task print_verdict();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Outputs are looked at mid-cycle, where they are settled, then the next edge is awaited.
   task pins(input logic en, input chg_pkg::reg_sel_t s, input logic oe);
      @(negedge clk_i);
      chk({27'h0, chg_en, reg_sel, st_oe, st_n}, {27'h0, en, s, oe, !oe});
      @(posedge clk_i);
   endtask

   task settle(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // One classic cycle; the request holds until ack is seen at an edge.
   task xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
             output logic [31:0] r);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      r = rdat;
      if (n >= 20) begin
         fail_count++;
         $display("[ERR] %0t bus acknowledge never came", $time);
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask

   // Hang guard, far beyond the few hundred cycles the sequence needs.
   initial begin
      #20000;
      fail_count++;
      print_verdict();
   end

   initial begin
      {rstn_i, cyc, stb, we, adr, sel, wdat, fl, drv, dval} = '0;
      fail_count = 0;
      checked = 0;
      settle(16);
      rstn_i <= 1'b1;
      settle(1);
      xfer(1'b0, chg_pkg::CTRL_OFS, 4'hF, 32'h0, q);
      chk(q, 32'h1);
      xfer(1'b1, chg_pkg::CTRL_OFS, 4'hF, 32'h0, q);
      xfer(1'b1, chg_pkg::CTRL_OFS, 4'hE, 32'h1, q);
      xfer(1'b0, chg_pkg::CTRL_OFS, 4'hF, 32'h0, q);
      chk(q, 32'h0);
      xfer(1'b1, 8'h08, 4'hF, 32'hFFFFFFFF, q);
      xfer(1'b0, 8'h08, 4'hF, 32'h0, q);
      chk(q, 32'h0);
      xfer(1'b1, chg_pkg::CTRL_OFS, 4'h1, 32'h1, q);
      fl[0] <= 1'b1;
      settle(6);
      pins(1'b1, chg_pkg::REG_PRE, 1'b1);
      fl[4] <= 1'b1;
      settle(20);
      @(negedge clk_i);
      chk({30'h0, level}, {30'h0, chg_pkg::LVL_100});
      @(posedge clk_i);
      fl[5] <= 1'b1;
      settle(6);
      pins(1'b1, chg_pkg::REG_CV, 1'b1);
      fl[8] <= 1'b1;
      fl[5] <= 1'b0;
      settle(6);
      pins(1'b1, chg_pkg::REG_CC, 1'b1);
      fl[8] <= 1'b0;
      fl[5] <= 1'b1;
      fl[7] <= 1'b1;
      settle(8);
      pins(1'b0, chg_pkg::REG_OFF, 1'b0);
      drv <= 1'b1;
      settle(6);
      pins(1'b1, chg_pkg::REG_CV, 1'b0);
      drv <= 1'b0;
      settle(6);
      pins(1'b0, chg_pkg::REG_OFF, 1'b0);
      fl[7:5] <= 3'h2;
      settle(8);
      pins(1'b1, chg_pkg::REG_CC, 1'b0);
      fl[6] <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         fl[i] <= ~fl[i];
         settle(6);
         pins(1'b0, chg_pkg::REG_OFF, 1'b0);
         fl[i] <= ~fl[i];
         settle(8);
         pins(1'b1, chg_pkg::REG_CC, 1'b1);
      end
      drv <= 1'b1;
      settle(6);
      pins(1'b1, chg_pkg::REG_CC, 1'b1);
      fl[7:5] <= 3'h5;
      dval <= 1'b1;
      settle(8);
      pins(1'b0, chg_pkg::REG_OFF, 1'b0);
      xfer(1'b0, chg_pkg::STAT_OFS, 4'hF, 32'h0, q);
      chk({31'h0, q[chg_pkg::STAT_LATCH_BIT]}, 32'h1);
      drv <= 1'b0;
      settle(6);
      @(negedge clk_i);
      chk({31'h0, st_oe}, 32'h1);
      @(posedge clk_i);
      settle(30);
      pins(1'b0, chg_pkg::REG_OFF, 1'b0);
      print_verdict();
   end
endmodule

/* hdl/charge_ctrl.sv */
// Charge mode controller: mode decode, charge sequence, status pin and register slave.
//
// How it works
// - Mode pin decodes to low (float), mid (monitor) or high (disabled).
// - Mid range: charge normally, then switch output off and enter monitor.
// - Low range: float-charge after termination; monitor exits into float charge.
// - High range latches disable until the pin is pulled below high.
// - Leaving high starts a new charge cycle and asserts the status pin.
// - Cycle done in mid range: output and status off, then monitor.
// - Monitor starts a re-charge when battery falls below re-charge level.
// - Monitor keeps decoding the mode pin and reacts to low and high.
// - Low during monitor turns charging on without asserting status.
// - Forced re-charge ends at termination current once the pin is back at mid, and returns to monitor.
// - Forced re-charge is accepted only in monitor and never touches the status pin.
// - Status pin goes low as charging begins with a valid supply.
// - Status released on termination, disable, or supply removal.
// - Cycle starting on a full battery holds status about 750 us.
// - Automatic re-charge cycles leave the status pin released.
// - Current regulation until above transition level, then voltage regulation.
// - Voltage regulation reverts to current when current exceeds 105 percent.
// - Below pre-charge threshold, command 20 percent pre-charge current.
// - Fast charge steps the current through 20, 60 and 100 percent.
// - Termination when current in voltage regulation drops below 10 percent.
//
// Design decisions made here: register access over Wishbone and the register addresses.
module charge_ctrl #(
   parameter int unsigned STATUS_MIN_CYC = chg_pkg::STATUS_MIN_CYC,
   parameter int unsigned SOFT_STEP_CYC  = chg_pkg::SOFT_STEP_CYC
) (
   // Clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rstn_i,
   // Wishbone slave
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [7:0]                 wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [31:0]                wb_dat_i,
   output logic      [31:0]                wb_dat_o,
   output logic                            wb_ack_o,
   // Asynchronous comparator flags
   input  wire logic [chg_pkg::NFLAGS-1:0] flags_i,
   // Charger controls
   output logic                            chg_en_o,
   output chg_pkg::reg_sel_t               reg_sel_o,
   output chg_pkg::level_t                 level_o,
   // Open-drain status pin
   output logic                            charge_status_n_o,
   output logic                            charge_status_oe_o
);

   typedef struct packed {
      chg_pkg::state_t           st;
      logic                      hi_latch;
      logic                      supply_prev;
      logic                      status_on;
      logic                      rel_pend;
      logic                      forced;
      logic [chg_pkg::CNT_W-1:0] min_cnt;
      logic                      allow;
      logic                      chg_en;
      chg_pkg::reg_sel_t         sel;
      logic                      stat_n;
      logic                      ack;
      logic [31:0]               rdata;
   } ctrl_t;

   localparam logic [chg_pkg::CNT_W-1:0] MIN_LOAD = chg_pkg::CNT_W'(STATUS_MIN_CYC - 1);
   localparam ctrl_t RESET_VAL = '{
      st: chg_pkg::ST_IDLE, hi_latch: 1'b0, supply_prev: 1'b0, status_on: 1'b0,
      rel_pend: 1'b0, forced: 1'b0, min_cnt: '0, allow: chg_pkg::CTRL_ALLOW_RST,
      chg_en: 1'b0, sel: chg_pkg::REG_OFF, stat_n: 1'b1, ack: 1'b0, rdata: '0};

   ctrl_t           q;
   ctrl_t           d;
   chg_pkg::level_t level;
   logic            ss_hold;
   logic            supply;
   logic            disabled;
   logic            leave_dis;
   logic            assert_req;
   logic            term_rel;
   logic            wr_ctrl;

   flag_if fl ();

   // -------------------------------------------------------------------
   // Submodules
   // -------------------------------------------------------------------
   flag_sync u_sync (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .raw_i  (flags_i),
      .fl     (fl)
   );

   // The level restarts at 20 percent whenever fast charge is left entirely.
   assign ss_hold = !(q.st == chg_pkg::ST_CC || q.st == chg_pkg::ST_CV ||
                      q.st == chg_pkg::ST_FLOAT);

   soft_start #(
      .STEP_CYC (SOFT_STEP_CYC)
   ) u_ss (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .hold_i  (ss_hold),
      .level_o (level)
   );

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   // Decisions read only synchronised flags from the interface.
   always_comb begin
      d          = q;
      assert_req = 1'b0;
      term_rel   = 1'b0;
      wr_ctrl    = 1'b0;

      // Supply counts only between lockout and over-voltage.
      supply = fl.supply_ok && !fl.over_volt;

      // High is latched; only a pull below high releases it.
      if (fl.mode_high) begin
         d.hi_latch = 1'b1;
      end else begin
         d.hi_latch = 1'b0;
      end
      leave_dis  = q.hi_latch && !fl.mode_high;
      disabled   = q.hi_latch || !q.allow;
      d.supply_prev = supply;

      // Charge sequence.
      case (q.st)
         chg_pkg::ST_IDLE, chg_pkg::ST_DIS: begin
            if (supply && !disabled) begin
               d.st       = chg_pkg::ST_PRE;
               assert_req = 1'b1;
            end
         end
         chg_pkg::ST_PRE: begin
            if (fl.above_preq) begin
               d.st = chg_pkg::ST_CC;
            end
         end
         chg_pkg::ST_CC: begin
            if (fl.above_cvtrans) begin
               d.st = chg_pkg::ST_CV;
            end
         end
         chg_pkg::ST_CV: begin
            if (fl.above_max) begin
               d.st = chg_pkg::ST_CC;
            end else if (fl.below_term) begin
               term_rel = 1'b1;
               d.forced = 1'b0;
               if (fl.mode_low) begin
                  d.st = chg_pkg::ST_FLOAT;
               end else begin
                  d.st = chg_pkg::ST_MON;
               end
            end
         end
         chg_pkg::ST_FLOAT: begin
            // Float charge holds while low; a return to mid ends it at termination.
            if (!fl.mode_low && fl.below_term) begin
               d.st     = chg_pkg::ST_MON;
               d.forced = 1'b0;
               term_rel = !q.forced;
            end
         end
         chg_pkg::ST_MON: begin
            if (fl.mode_low) begin
               d.st     = chg_pkg::ST_FLOAT;
               d.forced = 1'b1;
            end else if (fl.below_rechg) begin
               d.st = chg_pkg::ST_PRE;
            end
         end
         default: begin
            d.st = chg_pkg::ST_IDLE;
         end
      endcase

      // Disable and supply loss override the sequence and free the pin at once.
      if (disabled) begin
         d.st        = chg_pkg::ST_DIS;
         d.status_on = 1'b0;
         d.rel_pend  = 1'b0;
         d.forced    = 1'b0;
         assert_req  = 1'b0;
      end else if (!supply) begin
         // A forced request with no supply is harmless: nothing is driven.
         d.st        = chg_pkg::ST_IDLE;
         d.status_on = 1'b0;
         d.rel_pend  = 1'b0;
         d.forced    = 1'b0;
         assert_req  = 1'b0;
      end else if (leave_dis) begin
         d.st       = chg_pkg::ST_PRE;
         assert_req = 1'b1;
      end

      // Status pin timing; a quick termination waits out the least time.
      if (q.min_cnt != '0) begin
         d.min_cnt = q.min_cnt - chg_pkg::CNT_W'(1);
      end
      if (assert_req) begin
         d.status_on = 1'b1;
         d.rel_pend  = 1'b0;
         d.min_cnt   = MIN_LOAD;
      end else if (term_rel || q.rel_pend) begin
         if (q.min_cnt == '0) begin
            d.status_on = 1'b0;
            d.rel_pend  = 1'b0;
         end else begin
            d.rel_pend = q.status_on;
         end
      end

      // Registered outputs follow the next state.
      case (d.st)
         chg_pkg::ST_PRE:   d.sel = chg_pkg::REG_PRE;
         chg_pkg::ST_CC:    d.sel = chg_pkg::REG_CC;
         chg_pkg::ST_CV:    d.sel = chg_pkg::REG_CV;
         chg_pkg::ST_FLOAT: d.sel = chg_pkg::REG_CV;
         default:           d.sel = chg_pkg::REG_OFF;
      endcase
      d.chg_en = (d.sel != chg_pkg::REG_OFF);
      d.stat_n = !d.status_on;

      // Wishbone: acknowledge one cycle after the request, then drop.
      d.ack = wb_cyc_i && wb_stb_i && !q.ack;
      wr_ctrl = wb_cyc_i && wb_stb_i && wb_we_i && q.ack && wb_sel_i[0] &&
                (wb_adr_i == chg_pkg::CTRL_OFS);
      if (wr_ctrl) begin
         d.allow = wb_dat_i[chg_pkg::CTRL_ALLOW_BIT];
      end
      d.rdata = '0;
      if (d.ack && !wb_we_i) begin
         if (wb_adr_i == chg_pkg::CTRL_OFS) begin
            d.rdata[chg_pkg::CTRL_ALLOW_BIT] = q.allow;
         end else if (wb_adr_i == chg_pkg::STAT_OFS) begin
            d.rdata[chg_pkg::STAT_STATE_LSB +: 3]          = q.st;
            d.rdata[chg_pkg::STAT_SEL_LSB +: 2]            = q.sel;
            d.rdata[chg_pkg::STAT_LEVEL_LSB +: 2]          = level;
            d.rdata[chg_pkg::STAT_CHG_BIT]                 = q.chg_en;
            d.rdata[chg_pkg::STAT_STATUS_BIT]              = q.status_on;
            d.rdata[chg_pkg::STAT_LATCH_BIT]               = q.hi_latch;
            d.rdata[chg_pkg::STAT_FORCED_BIT]              = q.forced;
            d.rdata[chg_pkg::STAT_FLAGS_LSB]               = fl.supply_ok;
            d.rdata[chg_pkg::STAT_FLAGS_LSB + 1]           = fl.over_volt;
            d.rdata[chg_pkg::STAT_FLAGS_LSB + 2]           = fl.mode_low;
            d.rdata[chg_pkg::STAT_FLAGS_LSB + 3]           = fl.mode_high;
            d.rdata[chg_pkg::STAT_FLAGS_LSB + 4]           = fl.above_preq;
            d.rdata[chg_pkg::STAT_FLAGS_LSB + 5]           = fl.above_cvtrans;
            d.rdata[chg_pkg::STAT_FLAGS_LSB + 6]           = fl.below_rechg;
            d.rdata[chg_pkg::STAT_FLAGS_LSB + 7]           = fl.below_term;
            d.rdata[chg_pkg::STAT_FLAGS_LSB + 8]           = fl.above_max;
         end
      end
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q <= RESET_VAL;
      end else begin
         q <= d;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   // The pin is driven low only while enabled, so its value flop stays at zero then.
   assign wb_dat_o           = q.rdata;
   assign wb_ack_o           = q.ack;
   assign chg_en_o           = q.chg_en;
   assign reg_sel_o          = q.sel;
   assign level_o            = level;
   assign charge_status_n_o  = q.stat_n;
   assign charge_status_oe_o = q.status_on;

endmodule

/* hdl/chg_pkg.sv */
// Shared constants, codes and types of the charge mode controller.
package chg_pkg;

   // -------------------------------------------------------------------
   // Clock and timing
   // -------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS    = 5000;
   localparam int unsigned STATUS_MIN_NS    = 750000;
   localparam int unsigned STATUS_MIN_CYC   = (STATUS_MIN_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned SOFT_STEP_NS     = 100000;
   localparam int unsigned SOFT_STEP_CYC    = (SOFT_STEP_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned CNT_W            = 18;

   // -------------------------------------------------------------------
   // Register map and fields
   // -------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS          = 8'h00;
   localparam logic [7:0] STAT_OFS          = 8'h04;
   localparam int unsigned CTRL_ALLOW_BIT   = 0;
   localparam logic        CTRL_ALLOW_RST   = 1'b1;
   localparam int unsigned STAT_STATE_LSB   = 0;
   localparam int unsigned STAT_SEL_LSB     = 4;
   localparam int unsigned STAT_LEVEL_LSB   = 6;
   localparam int unsigned STAT_CHG_BIT     = 8;
   localparam int unsigned STAT_STATUS_BIT  = 9;
   localparam int unsigned STAT_LATCH_BIT   = 10;
   localparam int unsigned STAT_FORCED_BIT  = 11;
   localparam int unsigned STAT_FLAGS_LSB   = 16;

   // -------------------------------------------------------------------
   // Comparator flags, in order of the raw input vector
   // -------------------------------------------------------------------
   localparam int unsigned NFLAGS           = 9;
   localparam int unsigned F_SUPPLY_OK      = 0;
   localparam int unsigned F_OVER_VOLT      = 1;
   localparam int unsigned F_MODE_LOW       = 2;
   localparam int unsigned F_MODE_HIGH      = 3;
   localparam int unsigned F_ABOVE_PREQ     = 4;
   localparam int unsigned F_ABOVE_CVTRANS  = 5;
   localparam int unsigned F_BELOW_RECHG    = 6;
   localparam int unsigned F_BELOW_TERM     = 7;
   localparam int unsigned F_ABOVE_MAX      = 8;

   // -------------------------------------------------------------------
   // Codes
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      REG_OFF = 2'h0,
      REG_PRE = 2'h1,
      REG_CC  = 2'h2,
      REG_CV  = 2'h3
   } reg_sel_t;

   typedef enum logic [1:0] {
      LVL_20  = 2'h0,
      LVL_60  = 2'h1,
      LVL_100 = 2'h2
   } level_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_PRE   = 3'h1,
      ST_CC    = 3'h3,
      ST_CV    = 3'h2,
      ST_FLOAT = 3'h6,
      ST_MON   = 3'h4,
      ST_DIS   = 3'h5
   } state_t;

endpackage

/* hdl/flag_if.sv */
// Synchronised comparator flags passed from the synchroniser to the controller.
interface flag_if;
   logic supply_ok;
   logic over_volt;
   logic mode_low;
   logic mode_high;
   logic above_preq;
   logic above_cvtrans;
   logic below_rechg;
   logic below_term;
   logic above_max;

   modport src (output supply_ok, over_volt, mode_low, mode_high, above_preq,
                output above_cvtrans, below_rechg, below_term, above_max);
   modport dst (input supply_ok, over_volt, mode_low, mode_high, above_preq,
                input above_cvtrans, below_rechg, below_term, above_max);
endinterface

/* hdl/flag_sync.sv */
// Two-stage synchroniser for the asynchronous comparator flags.
module flag_sync (
   // Clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rstn_i,
   // Raw flags and synchronised result
   input  wire logic [chg_pkg::NFLAGS-1:0] raw_i,
   flag_if.src                             fl
);

   typedef struct packed {
      logic [chg_pkg::NFLAGS-1:0] s1;
      logic [chg_pkg::NFLAGS-1:0] s2;
   } sync_t;

   sync_t q;
   sync_t d;

   // -------------------------------------------------------------------
   // Stages
   // -------------------------------------------------------------------
   // Each flag is one generate entry; the first stage feeds only the second.
   for (genvar i = 0; i < chg_pkg::NFLAGS; i++) begin : g_bit
      always_comb begin
         d.s1[i] = raw_i[i];
         d.s2[i] = q.s1[i];
      end
   end

   // Both stages in one register.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Only the second stage is ever handed on.
   assign fl.supply_ok     = q.s2[chg_pkg::F_SUPPLY_OK];
   assign fl.over_volt     = q.s2[chg_pkg::F_OVER_VOLT];
   assign fl.mode_low      = q.s2[chg_pkg::F_MODE_LOW];
   assign fl.mode_high     = q.s2[chg_pkg::F_MODE_HIGH];
   assign fl.above_preq    = q.s2[chg_pkg::F_ABOVE_PREQ];
   assign fl.above_cvtrans = q.s2[chg_pkg::F_ABOVE_CVTRANS];
   assign fl.below_rechg   = q.s2[chg_pkg::F_BELOW_RECHG];
   assign fl.below_term    = q.s2[chg_pkg::F_BELOW_TERM];
   assign fl.above_max     = q.s2[chg_pkg::F_ABOVE_MAX];

endmodule

/* hdl/soft_start.sv */
// Soft-start stepper of the commanded fast-charge current level.
module soft_start #(
   parameter int unsigned STEP_CYC = chg_pkg::SOFT_STEP_CYC
) (
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          rstn_i,
   // Control and level
   input  wire logic          hold_i,
   output chg_pkg::level_t    level_o
);

   typedef struct packed {
      chg_pkg::level_t           level;
      logic [chg_pkg::CNT_W-1:0] cnt;
   } ss_t;

   localparam logic [chg_pkg::CNT_W-1:0] STEP = chg_pkg::CNT_W'(STEP_CYC - 1);

   ss_t q;
   ss_t d;

   // -------------------------------------------------------------------
   // Stepping
   // -------------------------------------------------------------------
   // Held at the lowest level outside fast charge, so pre-charge sees 20 percent.
   always_comb begin
      d = q;
      if (hold_i) begin
         d.level = chg_pkg::LVL_20;
         d.cnt   = STEP;
      end else if (q.cnt != '0) begin
         d.cnt = q.cnt - chg_pkg::CNT_W'(1);
      end else if (q.level == chg_pkg::LVL_20) begin
         d.level = chg_pkg::LVL_60;
         d.cnt   = STEP;
      end else begin
         d.level = chg_pkg::LVL_100;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q <= '{level: chg_pkg::LVL_20, cnt: '0};
      end else begin
         q <= d;
      end
   end

   assign level_o = q.level;

endmodule
